// ### hdl/fcp_host.sv
// Notes on behaviour
// R01: reset low returns flash control logic to standby, ready for array reads.
// R02: host selects flash by driving chip select low; only then transfers occur.
// R03: flash drives data lines only while output drive is low.
// R04: write strobe low means host-to-flash; high means flash-to-host.
// R05: address width per density variant, 26 down to 23 lines.
// R06: edge sector lock low makes flash refuse program/erase of edge sector.
// R07: flash pulls ready/busy low during algorithms and resets.
// R08: ready/busy valid after last write strobe rise, power-up, reset fall.
// R09: program in erase suspend shows busy; suspended reads and standby ready.
// R10: failed program/erase stays busy until status cleared and reset command.
// R11: reset held minimum pulse aborts, tristates, clears status, idles engine.
// R12: flash ignores chip select for the whole reset recovery time.
// R13: host keeps chip select high during hardware reset.
// R14: host restarts operations cut short by hardware reset once ready.
// R15: host never drives output drive and write strobe low together.
// R16: deselected flash ignores inputs, outputs high impedance except ready/busy.
// R17: ready/busy is open drain; low enable while busy, pull-up implied.
`timescale 1ns/1ns
`default_nettype none
module fcp_host #(
   parameter int ADDR_W = fcp_pkg::ADDR_W_MAX
) (
   // clock and reset
   input  wire logic                     clk,
   input  wire logic                     reset_n,
   // user request side
   input  wire logic                     req_valid,
   output logic                          req_ready,
   input  wire fcp_pkg::fcp_req_t        req,
   input  wire logic                     hard_reset_req,
   output logic                          rsp_valid,
   output logic [fcp_pkg::DATA_W-1:0]    rsp_rdata,
   output logic                          flash_busy,
   output logic                          op_aborted,
   input  wire logic                     edge_lock_en,
   // flash pins
   output logic                          hard_reset_low,
   output logic                          chip_select_low,
   output logic                          output_drive_low,
   output logic                          write_strobe_low,
   output logic                          edge_sector_lock_low,
   output logic [ADDR_W-1:0]             address_lines,
   input  wire logic [fcp_pkg::DATA_W-1:0] data_lines_in,
   output logic [fcp_pkg::DATA_W-1:0]    data_lines_out,
   output logic                          data_lines_oe,
   input  wire logic                     ready_busy_in
);
   // ==========================================
   // pin synchronisers
   logic                       rb_s1_reg, rb_s2_reg;
   logic [fcp_pkg::DATA_W-1:0] dq_s1_reg, dq_s2_reg;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rb_s1_reg <= 1'b1;
         rb_s2_reg <= 1'b1;
         dq_s1_reg <= 16'h0000;
         dq_s2_reg <= 16'h0000;
      end else begin
         rb_s1_reg <= ready_busy_in;
         rb_s2_reg <= rb_s1_reg;
         dq_s1_reg <= data_lines_in;
         dq_s2_reg <= dq_s1_reg;
      end
   end
   // open-drain pin: low means busy, pull-up gives high when released
   assign flash_busy = ~rb_s2_reg; // R07 R17

   // ==========================================
   // sequencer constants
   localparam int            CW        = fcp_pkg::CNT_W;
   localparam logic [CW-1:0] LD_PULSE  = CW'(fcp_pkg::RESET_PULSE_CYC - 1);
   localparam logic [CW-1:0] LD_RECOV  = CW'(fcp_pkg::RESET_RECOV_CYC - 1);
   localparam logic [CW-1:0] LD_SETUP  = CW'(fcp_pkg::OP_SETUP_CYC - 1);
   localparam logic [CW-1:0] LD_STROBE = CW'(fcp_pkg::STROBE_CYC - 1);
   localparam logic [CW-1:0] LD_ZERO   = CW'(0);
   localparam logic [CW-1:0] LD_ONE    = CW'(1);

   // ==========================================
   // state, request and pin registers
   fcp_pkg::fcp_state_t        state_reg;
   fcp_pkg::fcp_state_t        state_next;
   logic [CW-1:0]              cnt_reg;
   logic [CW-1:0]              cnt_next;
   logic [CW-1:0]              cnt_load;
   logic                       pend_reg;
   logic                       pend_next;
   logic                       write_reg;
   logic [ADDR_W-1:0]          addr_reg;
   logic [fcp_pkg::DATA_W-1:0] wdata_reg;
   logic [fcp_pkg::DATA_W-1:0] rdata_reg;
   logic                       rsp_valid_reg;
   logic                       aborted_reg;
   logic                       hard_reset_low_reg;
   logic                       hard_reset_low_next;
   logic                       chip_select_low_reg;
   logic                       chip_select_low_next;
   logic                       output_drive_low_reg;
   logic                       output_drive_low_next;
   logic                       write_strobe_low_reg;
   logic                       write_strobe_low_next;
   logic                       data_oe_reg;
   logic                       data_oe_next;
   logic                       edge_lock_low_reg;

   // ==========================================
   // decode
   logic                       st_idle;
   logic                       st_setup;
   logic                       st_strobe;
   logic                       in_xfer;
   logic                       cnt_zero;
   logic                       accept;
   logic                       restart;
   logic                       abort;
   logic                       strobe_done;
   logic                       rd_capture;
   logic                       nx_reset;
   logic                       nx_setup;
   logic                       nx_strobe;
   logic                       nx_release;

   assign st_idle     = (state_reg == fcp_pkg::FCP_IDLE);
   assign st_setup    = (state_reg == fcp_pkg::FCP_SETUP);
   assign st_strobe   = (state_reg == fcp_pkg::FCP_STROBE);
   assign in_xfer     = st_setup || st_strobe;
   assign cnt_zero    = (cnt_reg == LD_ZERO);
   // a hard reset request wins over a new request in the same cycle
   assign req_ready   = st_idle && !pend_reg && !hard_reset_req;
   assign accept      = req_valid && req_ready;
   // a cut-short transfer waits for ready before it is issued again
   assign restart     = st_idle && pend_reg && !flash_busy
                        && !hard_reset_req; // R14 R10
   assign abort       = hard_reset_req && in_xfer; // R14
   assign strobe_done = st_strobe && cnt_zero && !hard_reset_req;
   assign rd_capture  = strobe_done && !write_reg;
   assign nx_reset    = (state_next == fcp_pkg::FCP_RESET);
   assign nx_setup    = (state_next == fcp_pkg::FCP_SETUP);
   assign nx_strobe   = (state_next == fcp_pkg::FCP_STROBE);
   assign nx_release  = (state_next == fcp_pkg::FCP_RELEASE);

   // ==========================================
   // next state
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         fcp_pkg::FCP_RESET: begin
            if (cnt_zero) begin
               state_next = fcp_pkg::FCP_RECOV; // R11
            end
         end
         fcp_pkg::FCP_RECOV: begin
            if (cnt_zero) begin
               state_next = fcp_pkg::FCP_IDLE; // R12
            end
         end
         fcp_pkg::FCP_IDLE: begin
            if (hard_reset_req) begin
               state_next = fcp_pkg::FCP_RESET; // R01
            end else if (restart || accept) begin
               state_next = fcp_pkg::FCP_SETUP; // R14
            end
         end
         fcp_pkg::FCP_SETUP: begin
            if (hard_reset_req) begin
               state_next = fcp_pkg::FCP_RESET;
            end else if (cnt_zero) begin
               state_next = fcp_pkg::FCP_STROBE;
            end
         end
         fcp_pkg::FCP_STROBE: begin
            if (hard_reset_req) begin
               state_next = fcp_pkg::FCP_RESET;
            end else if (cnt_zero) begin
               state_next = fcp_pkg::FCP_RELEASE;
            end
         end
         fcp_pkg::FCP_RELEASE: begin
            if (hard_reset_req) begin
               state_next = fcp_pkg::FCP_RESET;
            end else begin
               state_next = fcp_pkg::FCP_IDLE;
            end
         end
         default: begin
            state_next = fcp_pkg::FCP_RESET;
         end
      endcase
   end

   // phase lengths; idle and release need no count
   always_comb begin
      cnt_load = LD_ZERO;
      unique case (state_next)
         fcp_pkg::FCP_RESET: begin
            cnt_load = LD_PULSE; // R11
         end
         fcp_pkg::FCP_RECOV: begin
            cnt_load = LD_RECOV; // R12
         end
         fcp_pkg::FCP_SETUP: begin
            cnt_load = LD_SETUP;
         end
         fcp_pkg::FCP_STROBE: begin
            cnt_load = LD_STROBE;
         end
         default: begin
            cnt_load = LD_ZERO;
         end
      endcase
   end

   assign cnt_next  = (state_next != state_reg) ? cnt_load :
                      (cnt_zero ? cnt_reg : cnt_reg - LD_ONE);
   assign pend_next = accept ? 1'b1 : (strobe_done ? 1'b0 : pend_reg); // R14

   // ==========================================
   // pin levels for the coming state
   assign hard_reset_low_next   = !nx_reset; // R01 R11
   // select stays high through reset and recovery
   assign chip_select_low_next  = !(nx_setup || nx_strobe); // R02 R12 R13
   // only one of the two strobes is ever low
   assign output_drive_low_next = !(nx_strobe && !write_reg); // R04 R15
   assign write_strobe_low_next = !(nx_strobe && write_reg); // R04 R15
   // write data is held one cycle past the strobe's rising edge
   assign data_oe_next          = (nx_strobe || nx_release) && write_reg;

   // ==========================================
   // sequencer registers
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= fcp_pkg::FCP_RESET; // R01
         cnt_reg   <= LD_PULSE;
         pend_reg  <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
         pend_reg  <= pend_next;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         write_reg <= 1'b0;
         addr_reg  <= '0;
         wdata_reg <= '0;
      end else if (accept) begin
         write_reg <= req.write;
         addr_reg  <= req.addr[ADDR_W-1:0]; // R05
         wdata_reg <= req.wdata;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rsp_valid_reg <= 1'b0;
         aborted_reg   <= 1'b0;
         rdata_reg     <= '0;
      end else begin
         rsp_valid_reg <= strobe_done;
         aborted_reg   <= abort; // R14
         if (rd_capture) begin
            rdata_reg <= dq_s2_reg;
         end
      end
   end

   // pins come straight from flops, so no glitch reaches the flash
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         hard_reset_low_reg   <= 1'b0;
         chip_select_low_reg  <= 1'b1;
         output_drive_low_reg <= 1'b1;
         write_strobe_low_reg <= 1'b1;
         data_oe_reg          <= 1'b0;
         edge_lock_low_reg    <= 1'b1;
      end else begin
         hard_reset_low_reg   <= hard_reset_low_next;
         chip_select_low_reg  <= chip_select_low_next;
         output_drive_low_reg <= output_drive_low_next;
         write_strobe_low_reg <= write_strobe_low_next;
         data_oe_reg          <= data_oe_next;
         edge_lock_low_reg    <= ~edge_lock_en; // R06
      end
   end

   // ==========================================
   // outputs
   assign hard_reset_low       = hard_reset_low_reg;
   assign chip_select_low      = chip_select_low_reg;
   assign output_drive_low     = output_drive_low_reg;
   assign write_strobe_low     = write_strobe_low_reg;
   assign edge_sector_lock_low = edge_lock_low_reg;
   assign address_lines        = addr_reg;
   assign data_lines_out       = wdata_reg;
   assign data_lines_oe        = data_oe_reg;
   assign rsp_valid            = rsp_valid_reg;
   assign rsp_rdata            = rdata_reg;
   assign op_aborted           = aborted_reg;
endmodule
`default_nettype wire

// ### pkg/fcp_pkg.sv
`default_nettype none
package fcp_pkg;
   // ==========================================
   // widths
   localparam int ADDR_W_MAX = 26;
   localparam int ADDR_W_MIN = 23;
   localparam int DATA_W     = 16;
   // ==========================================
   // timing (ns) and derived cycle counts at 100 MHz
   localparam int CLK_NS           = 10;
   localparam int RESET_PULSE_NS   = 200;
   localparam int RESET_RECOV_NS   = 50;
   localparam int OP_SETUP_NS      = 20;
   localparam int RESET_PULSE_CYC  = (RESET_PULSE_NS + CLK_NS - 1) / CLK_NS;
   localparam int RESET_RECOV_CYC  = (RESET_RECOV_NS + CLK_NS - 1) / CLK_NS;
   localparam int OP_SETUP_CYC     = (OP_SETUP_NS + CLK_NS - 1) / CLK_NS;
   // read data crosses two synchroniser flops, so the strobe spans them too
   localparam int SYNC_CYC         = 2;
   localparam int STROBE_CYC       = OP_SETUP_CYC + SYNC_CYC;
   localparam int CNT_W            = 16;
   // ==========================================
   // request carrier
   typedef struct packed {
      logic                  write;
      logic [ADDR_W_MAX-1:0] addr;
      logic [DATA_W-1:0]     wdata;
   } fcp_req_t;
   typedef enum logic [2:0] {
      FCP_RESET   = 3'h0,
      FCP_RECOV   = 3'h1,
      FCP_IDLE    = 3'h2,
      FCP_SETUP   = 3'h3,
      FCP_STROBE  = 3'h4,
      FCP_RELEASE = 3'h5
   } fcp_state_t;
endpackage
`default_nettype wire

// ### dv/fcp_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module fcp_monitor (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // flash pins
   input wire logic hard_reset_low,
   input wire logic chip_select_low,
   input wire logic output_drive_low,
   input wire logic write_strobe_low,
   input wire logic data_lines_oe
);
   // ==========================================
   // length of the current reset pulse
   logic [15:0] low_cnt_reg;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         low_cnt_reg <= 16'h0000;
      end else if (!hard_reset_low) begin
         low_cnt_reg <= low_cnt_reg + 16'h0001;
      end else begin
         low_cnt_reg <= 16'h0000;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   a_reset_width: assert property ($rose(hard_reset_low)
      |-> low_cnt_reg >= 16'(fcp_pkg::RESET_PULSE_CYC))
      else $error("reset pulse too short");
   // five cycles of recovery before any select
   a_recov_desel: assert property ($rose(hard_reset_low)
      |-> chip_select_low [*5])
      else $error("selected in recovery");
   a_read_sel: assert property (!output_drive_low |-> !chip_select_low)
      else $error("read while deselected");
   a_no_bus_fight: assert property (output_drive_low | write_strobe_low)
      else $error("strobes low together");
   a_reset_desel: assert property (!hard_reset_low |-> chip_select_low)
      else $error("selected in reset");
   a_write_sel: assert property (!write_strobe_low |-> !chip_select_low)
      else $error("write while deselected");
   a_write_drive: assert property (!write_strobe_low |-> data_lines_oe)
      else $error("write data undriven");
   c_write: cover property (!write_strobe_low);
   c_read: cover property (!output_drive_low);
   c_reset: cover property (!hard_reset_low);
   c_recov: cover property ($rose(hard_reset_low));
endmodule
bind fcp_host fcp_monitor mon (.*);
`default_nettype wire

// ### dv/fcp_flash_model.sv
`timescale 1ns/1ns
`default_nettype none
module fcp_flash_model (
   // control pins
   input  wire logic        hard_reset_low,
   input  wire logic        chip_select_low,
   input  wire logic        output_drive_low,
   input  wire logic        write_strobe_low,
   input  wire logic [25:0] address_lines,
   // data and status back to the host
   output logic      [15:0] data_lines_in,
   output logic             ready_busy_in
);
   int   wr_seq   = 0;
   int   done_seq = 0;
   logic alg_busy = 1'b0;
   // every write runs a short algorithm; no suspend is modelled
   always @(posedge write_strobe_low) begin
      if (hard_reset_low === 1'b1) begin
         wr_seq = wr_seq + 1;
         alg_busy = 1'b1;
         done_seq <= #300 wr_seq;
      end
   end
   always @(done_seq) begin
      if (done_seq == wr_seq) alg_busy = 1'b0;
   end
   // reset aborts the algorithm
   always @(negedge hard_reset_low) begin
      wr_seq = wr_seq + 1;
      alg_busy = 1'b0;
   end
   // drain low while busy or in reset; pull-up gives high otherwise
   assign ready_busy_in = hard_reset_low && !alg_busy;
   // released bus shows the inverse, not stale data
   assign data_lines_in = (!chip_select_low && !output_drive_low) ?
      (address_lines[15:0] ^ 16'ha5c3) :
      ~(address_lines[15:0] ^ 16'ha5c3);
endmodule
`default_nettype wire

// ### dv/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
   // ==========================================
   // signals
   logic              clk            = 1'b0;
   logic              reset_n        = 1'b0;
   logic              req_valid      = 1'b0;
   logic              hard_reset_req = 1'b0;
   logic              edge_lock_en   = 1'b0;
   logic              req_ready, rsp_valid, flash_busy, op_aborted;
   logic              hard_reset_low, chip_select_low, output_drive_low;
   logic              write_strobe_low, edge_sector_lock_low;
   logic              data_lines_oe, ready_busy_in;
   logic [15:0]       rsp_rdata, data_lines_in, data_lines_out;
   logic [15:0]       lf             = 16'h24c3;
   logic [25:0]       address_lines;
   fcp_pkg::fcp_req_t req            = '0;
   int                n_errors       = 0;
   int                compares       = 0;
   int                cyc            = 0;
   fcp_host        dut (.*);
   fcp_flash_model flash (.*);
   // ==========================================
   // helpers
   function automatic logic [15:0] nx(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   // the far side returns a pattern made from the address
   function automatic logic [15:0] exp_read(input logic [25:0] a);
      return a[15:0] ^ 16'ha5c3;
   endfunction
   task automatic fail(input string msg);
      n_errors++;
      $display("ERROR %0t %s", $time, msg);
   endtask
   task automatic check_val(input logic [31:0] got, input logic [31:0] exp,
                            input string msg);
      compares++;
      if (got !== exp) fail(msg);
   endtask
   task automatic check_flag(input logic got, input logic exp,
                             input string msg);
      compares++;
      if (got !== exp) fail(msg);
   endtask
   task automatic results();
      if (n_errors == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // called just after an edge; returns just after the accepting edge
   task automatic xfer(input logic wr, input logic [25:0] a,
                       input logic [15:0] d, input logic lock);
      req          = {wr, a, d};
      edge_lock_en = lock;
      req_valid    = 1'b1;
      @(posedge clk);
      while (req_ready !== 1'b1) @(posedge clk);
      #1 req_valid = 1'b0;
   endtask
   task automatic watch(input logic wr, input logic [25:0] a,
                        input logic [15:0] d, input logic lock);
      @(posedge clk);
      while ((wr ? write_strobe_low : output_drive_low) !== 1'b0)
         @(posedge clk);
      check_val(32'(address_lines), 32'(a), "address");
      check_flag(chip_select_low, 1'b0, "select");
      check_flag(edge_sector_lock_low, !lock, "edge lock");
      if (wr) check_val(32'(data_lines_out), 32'(d), "wdata");
      while (rsp_valid !== 1'b1) @(posedge clk);
      if (!wr) check_val(32'(rsp_rdata), 32'(exp_read(a)), "rdata");
      if (wr) begin
         repeat (2) @(posedge clk);
         check_flag(flash_busy, 1'b1, "busy after write");
      end
   endtask
   task automatic pulse_reset();
      hard_reset_req = 1'b1;
      @(posedge clk);
      #1 hard_reset_req = 1'b0;
   endtask
   // ==========================================
   // clock and timeout
   initial begin
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc > 5000) begin
         fail("timeout");
         results();
      end
   end
   // ==========================================
   // scenarios
   initial begin
      repeat (8) @(posedge clk);
      #1 reset_n = 1'b1;
      xfer(1'b1, 26'h3ffffff, 16'hffff, 1'b1);
      watch(1'b1, 26'h3ffffff, 16'hffff, 1'b1);
      @(posedge clk);
      #1 xfer(1'b0, 26'h0000000, 16'h0000, 1'b0);
      watch(1'b0, 26'h0000000, 16'h0000, 1'b0);
      repeat (24) begin
         @(posedge clk);
         #1 lf = nx(lf);
         xfer(lf[0], {lf[9:0], lf}, nx(lf), lf[3]);
         watch(lf[0], {lf[9:0], lf}, nx(lf), lf[3]);
      end
      // hard reset from idle
      @(posedge clk);
      #1 pulse_reset();
      repeat (3) @(posedge clk);
      check_flag(flash_busy, 1'b1, "busy in reset");
      check_flag(hard_reset_low, 1'b0, "reset pin");
      check_flag(chip_select_low, 1'b1, "select in reset");
      check_flag(req_ready, 1'b0, "ready in reset");
      // read cut short by a reset, then issued again by the host
      @(posedge clk);
      #1 xfer(1'b0, 26'h1234567, 16'h0000, 1'b0);
      @(posedge clk);
      #1 pulse_reset();
      @(posedge clk);
      check_flag(op_aborted, 1'b1, "abort flag");
      check_flag(hard_reset_low, 1'b0, "abort reset");
      while (rsp_valid !== 1'b1) @(posedge clk);
      check_val(32'(rsp_rdata), 32'(exp_read(26'h1234567)), "redo");
      results();
   end
endmodule
`default_nettype wire
